/* core/pss_regs.svh */
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_MHZ 200
`define PSS_TOPO_TIMEOUT_US 120
`define PSS_TOPO_CYC (`PSS_TOPO_TIMEOUT_US * `PSS_CLK_MHZ)
`define PSS_AUTOWU_DELAY_US 1000
`define PSS_RST_SHORT_US 1000
`define PSS_RST_LONG_US 10000
`define PSS_INIT_WIN_MS 256
// reset values
`define PSS_RST_DUR_RST 1'b0
`define PSS_SEL_RST 2'h0
// secured low-power-off command key and codes
`define PSS_LOW_POWER_OFF_KEY 8'hA5
`define PSS_LOW_POWER_OFF_SLEEP 2'h1
`define PSS_LOW_POWER_OFF_AUTO 2'h2
// wake source field positions
`define PSS_WAKE_CAN 0
`define PSS_WAKE_IO 1
`define PSS_WAKE_TMR 2
`endif

/* core/pss_pkg.sv */
package pss_pkg;
    typedef enum logic [3:0] {
        MM_TOPO = 4'h0, MM_PRE = 4'h1, MM_SEL = 4'h3, MM_REGS = 4'h2,
        MM_INIT = 4'h6, MM_NORMAL = 4'h7, MM_SLEEP = 4'h5, MM_AUTOWU = 4'h4,
        MM_DEEPFS = 4'hC, MM_LP_DEEPFS = 4'hD
    } pss_main_e;
    typedef enum logic [2:0] {
        SF_OFF = 3'h0, SF_SEL = 3'h1, SF_BIST = 3'h3, SF_RELEASE = 3'h2,
        SF_INIT = 3'h6, SF_WATCH = 3'h7, SF_ASSERT = 3'h5
    } pss_safe_e;
    typedef logic [2:0] pss_wake_t;
endpackage

/* core/pss_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// generic down-counter, loads on start, pulses done once at zero
module pss_timer #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [W-1:0] load_i,
    input wire logic tick_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt;
    logic run;
    logic [W-1:0] next_cnt;
    logic next_run;
    logic next_done;

    always_comb begin
        next_cnt = cnt;
        next_run = run;
        next_done = 1'b0;
        if (start_i) begin
            next_cnt = load_i;
            next_run = 1'b1;
        end else if (run && tick_i) begin
            if (cnt <= W'(1)) begin
                next_cnt = '0;
                next_run = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            run <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            run <= next_run;
            done_o <= next_done;
        end
    end

    assign busy_o = run;
endmodule // pss_timer
`default_nettype wire

/* core/pss_sequencer.sv */
// Notes on behaviour
// - power machine and safety machine run side by side; safety starts in REGS, main waits for safety INIT
// - each start-up senses gate pin; threshold before timeout locks buck-boost
// - after detection, pre-regulator soft-starts until pre_soft_done_i
// - config pin decode selects supply levels and deep fail-safe
// - core, auxiliary, analog supplies and transceiver supply start together
// - reset release enters INIT; INIT-only registers writable there only
// - commit write in INIT without pre-regulator undervoltage locks INIT-only registers and enters normal
// - secured sleep accepted only in normal; all off except keep-alive
// - sleep wakes on CAN, IO or timer; source recorded, both restart
// - every wake enables all regulators by default
// - pre-regulator undervoltage or secured command enters auto-wake, retry after delay
// - deep fail-safe with key low parks; key rising edge leaves
// - low-power-off keeps main registers, clears safety registers
// - first self-test failure releases reset but holds both safe outputs low
// - first self-test runs every start-up and wake
// - second self-test on request; must pass when auxiliary is safety critical
// - safety init starts at reset release, bounded window, locks on exit
// - first valid refresh leaves safety init for supervision at once
// - supervision left on any fault asserting reset, external request included
// - asserted reset held configured duration, released if no fault remains
// - safe-output handling and second test run inside init or supervision
// - fault reset duration selectable short or long; long after start-up
// - primary safe output held low after start-up until host releases it
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_sequencer #(
    parameter int unsigned AUTOWU_CYC = `PSS_AUTOWU_DELAY_US * `PSS_CLK_MHZ,
    parameter int unsigned RST_SHORT_CYC = `PSS_RST_SHORT_US * `PSS_CLK_MHZ,
    parameter int unsigned RST_LONG_CYC = `PSS_RST_LONG_US * `PSS_CLK_MHZ,
    parameter int unsigned INIT_WIN_CYC = `PSS_INIT_WIN_MS * 1000 * `PSS_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic gate_sense_high_i,
    input wire logic pre_soft_done_i,
    input wire logic [1:0] config_pin_code_i,
    input wire logic regs_soft_done_i,
    input wire logic pre_regulator_low_threshold_i,
    input wire logic init_write_i,
    input wire logic [7:0] init_data_i,
    input wire logic commit_write_i,
    input wire logic low_power_off_cmd_i,
    input wire logic [7:0] low_power_off_key_i,
    input wire logic [1:0] low_power_off_code_i,
    input wire logic keep_alive_used_i,
    input wire logic wake_can_i,
    input wire logic wake_io_i,
    input wire logic wake_timer_i,
    input wire logic deep_fs_event_i,
    input wire logic key_io_i,
    input wire logic bist1_done_i,
    input wire logic bist1_pass_i,
    input wire logic bist2_req_i,
    input wire logic bist2_done_i,
    input wire logic bist2_pass_i,
    input wire logic aux_critical_i,
    input wire logic rst_dur_write_i,
    input wire logic rst_dur_long_i,
    input wire logic refresh_ok_i,
    input wire logic fault_i,
    input wire logic ext_reset_req_i,
    input wire logic safe_release_req_i,
    input wire logic safe_fault_i,
    output logic lowside_gate_pin_src_o,
    output logic pre_regulator_output_en_o,
    output logic core_supply_en_o,
    output logic auxiliary_supply_en_o,
    output logic analog_ref_supply_en_o,
    output logic transceiver_supply_en_o,
    output logic keep_alive_supply_en_o,
    output logic buck_boost_o,
    output logic [1:0] supply_level_sel_o,
    output logic deep_fs_en_o,
    output logic [7:0] init_reg_o,
    output logic init_locked_o,
    output logic [2:0] wake_source_o,
    output logic bist1_run_o,
    output logic bist2_run_o,
    output logic bist1_ok_o,
    output logic bist2_ok_o,
    output logic mcu_reset_out_low_o,
    output logic primary_safe_out_o,
    output logic secondary_safe_out_o,
    output logic safety_init_phase_o,
    output logic reset_duration_config_o,
    output logic [3:0] main_state_o,
    output logic [2:0] safe_state_o
);
    ////////////////////////////////////////////////////////////////////
    // shared timer
    pss_pkg::pss_main_e m_st, next_m_st;
    pss_pkg::pss_safe_e s_st, next_s_st;
    logic tmr_start, tmr_busy, tmr_done;
    logic [31:0] tmr_load;

    pss_timer #(.W(32)) u_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(tmr_start),
        .load_i(tmr_load),
        .tick_i(1'b1),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    // main machine
    logic buck_boost, next_buck_boost, deep_fs_en, next_deep_fs_en;
    logic [1:0] lvl_sel, next_lvl_sel;
    logic [7:0] init_reg, next_init_reg;
    logic init_locked, next_init_locked;
    logic [2:0] wake_src, next_wake_src;
    logic key_q, next_key_q, safe_restart, m_entry;
    logic lp_secured;

    function automatic logic lp_ok(input logic [7:0] key, input logic [1:0] code, input logic [1:0] want);
        lp_ok = (key == `PSS_LOW_POWER_OFF_KEY) && (code == want);
    endfunction

    always_comb begin
        next_m_st = m_st;
        next_buck_boost = buck_boost;
        next_deep_fs_en = deep_fs_en;
        next_lvl_sel = lvl_sel;
        next_init_reg = init_reg;
        next_init_locked = init_locked;
        next_wake_src = wake_src;
        next_key_q = key_io_i;
        tmr_start = 1'b0;
        tmr_load = 32'h0;
        safe_restart = 1'b0;
        m_entry = 1'b0;
        lp_secured = 1'b0;
        unique case (m_st)
            pss_pkg::MM_TOPO: begin
                if (!tmr_busy && !tmr_done) begin
                    tmr_start = 1'b1;
                    tmr_load = 32'(`PSS_TOPO_CYC);
                end
                if (tmr_busy && gate_sense_high_i) begin
                    next_buck_boost = 1'b1;
                    next_m_st = pss_pkg::MM_PRE;
                end else if (tmr_done) begin
                    next_buck_boost = 1'b0;
                    next_m_st = pss_pkg::MM_PRE;
                end
            end
            pss_pkg::MM_PRE: begin
                if (pre_soft_done_i) begin
                    next_m_st = pss_pkg::MM_SEL;
                end
            end
            pss_pkg::MM_SEL: begin
                next_lvl_sel = config_pin_code_i;
                next_deep_fs_en = config_pin_code_i[1];
                next_m_st = pss_pkg::MM_REGS;
            end
            pss_pkg::MM_REGS: begin
                if (regs_soft_done_i && s_st == pss_pkg::SF_INIT) begin
                    next_m_st = pss_pkg::MM_INIT;
                    next_init_locked = 1'b0;
                end
            end
            pss_pkg::MM_INIT: begin
                if (init_write_i && !init_locked) begin
                    next_init_reg = init_data_i;
                end
                if (pre_regulator_low_threshold_i) begin
                    next_m_st = pss_pkg::MM_AUTOWU;
                end else if (commit_write_i) begin
                    next_init_locked = 1'b1;
                    next_m_st = pss_pkg::MM_NORMAL;
                end
            end
            pss_pkg::MM_NORMAL: begin
                lp_secured = low_power_off_cmd_i;
                if (deep_fs_event_i && deep_fs_en) begin
                    next_m_st = pss_pkg::MM_DEEPFS;
                end else if (pre_regulator_low_threshold_i) begin
                    next_m_st = pss_pkg::MM_AUTOWU;
                end else if (lp_secured && lp_ok(low_power_off_key_i, low_power_off_code_i, `PSS_LOW_POWER_OFF_SLEEP)) begin
                    next_m_st = pss_pkg::MM_SLEEP;
                end else if (lp_secured && lp_ok(low_power_off_key_i, low_power_off_code_i, `PSS_LOW_POWER_OFF_AUTO)) begin
                    next_m_st = pss_pkg::MM_AUTOWU;
                end
                // any other request is dropped
            end
            pss_pkg::MM_SLEEP: begin
                if (wake_can_i || wake_io_i || wake_timer_i) begin
                    next_wake_src[`PSS_WAKE_CAN] = wake_can_i;
                    next_wake_src[`PSS_WAKE_IO] = wake_io_i;
                    next_wake_src[`PSS_WAKE_TMR] = wake_timer_i;
                    m_entry = 1'b1;
                end
            end
            pss_pkg::MM_AUTOWU: begin
                if (tmr_done) begin
                    m_entry = 1'b1;
                end
            end
            pss_pkg::MM_DEEPFS: begin
                if (!key_io_i) begin
                    next_m_st = pss_pkg::MM_LP_DEEPFS;
                end
            end
            pss_pkg::MM_LP_DEEPFS: begin
                if (key_io_i && !key_q) begin
                    m_entry = 1'b1;
                end
            end
            default: next_m_st = pss_pkg::MM_TOPO;
        endcase
        if (m_entry) begin
            next_m_st = pss_pkg::MM_TOPO;
            safe_restart = 1'b1;
        end
        if (next_m_st == pss_pkg::MM_AUTOWU && m_st != pss_pkg::MM_AUTOWU) begin
            safe_restart = 1'b1;
        end
        if (next_m_st != m_st && (next_m_st == pss_pkg::MM_TOPO || next_m_st == pss_pkg::MM_AUTOWU)) begin
            tmr_start = 1'b1;
            tmr_load = (next_m_st == pss_pkg::MM_TOPO) ? 32'(`PSS_TOPO_CYC) : 32'(AUTOWU_CYC);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_st <= pss_pkg::MM_TOPO;
            buck_boost <= 1'b0;
            deep_fs_en <= 1'b0;
            lvl_sel <= `PSS_SEL_RST;
            init_reg <= 8'h00;
            init_locked <= 1'b0;
            wake_src <= 3'h0;
            key_q <= 1'b0;
        end else begin
            m_st <= next_m_st;
            buck_boost <= next_buck_boost;
            deep_fs_en <= next_deep_fs_en;
            lvl_sel <= next_lvl_sel;
            init_reg <= next_init_reg;
            init_locked <= next_init_locked;
            wake_src <= next_wake_src;
            key_q <= next_key_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // safety machine
    logic [31:0] s_cnt, next_s_cnt;
    logic long_rst, next_long_rst, rst_dur, next_rst_dur;
    logic b1_ok, next_b1_ok, b2_ok, next_b2_ok, b2_run, next_b2_run;
    logic fs0_rel, next_fs0_rel, fs1_rel, next_fs1_rel;
    logic reset_low, any_fault;

    assign any_fault = fault_i || ext_reset_req_i;

    always_comb begin
        next_s_st = s_st;
        next_s_cnt = s_cnt;
        next_long_rst = long_rst;
        next_rst_dur = rst_dur;
        next_b1_ok = b1_ok;
        next_b2_ok = b2_ok;
        next_b2_run = b2_run;
        next_fs0_rel = fs0_rel;
        next_fs1_rel = fs1_rel;
        unique case (s_st)
            pss_pkg::SF_OFF: begin
                if (m_st == pss_pkg::MM_REGS) begin
                    next_s_st = pss_pkg::SF_SEL;
                end
            end
            pss_pkg::SF_SEL: next_s_st = pss_pkg::SF_BIST;
            pss_pkg::SF_BIST: begin
                if (bist1_done_i) begin
                    next_b1_ok = bist1_pass_i;
                    next_s_st = pss_pkg::SF_RELEASE;
                    next_s_cnt = long_rst ? RST_LONG_CYC : (rst_dur ? RST_LONG_CYC : RST_SHORT_CYC);
                end
            end
            pss_pkg::SF_ASSERT, pss_pkg::SF_RELEASE: begin
                if (s_cnt != 32'h0) begin
                    next_s_cnt = s_cnt - 32'h1;
                end else if (!any_fault) begin
                    next_s_st = pss_pkg::SF_INIT;
                    next_long_rst = 1'b0;
                    next_s_cnt = INIT_WIN_CYC;
                end
            end
            pss_pkg::SF_INIT: begin
                if (rst_dur_write_i) begin
                    next_rst_dur = rst_dur_long_i;
                end
                if (refresh_ok_i) begin
                    next_s_st = pss_pkg::SF_WATCH;
                end else if (any_fault || s_cnt == 32'h0) begin
                    next_s_st = pss_pkg::SF_ASSERT;
                    next_fs0_rel = 1'b0;
                    next_s_cnt = rst_dur ? RST_LONG_CYC : RST_SHORT_CYC;
                end else begin
                    next_s_cnt = s_cnt - 32'h1;
                end
            end
            pss_pkg::SF_WATCH: begin
                if (any_fault) begin
                    next_s_st = pss_pkg::SF_ASSERT;
                    next_fs0_rel = 1'b0;
                    next_s_cnt = rst_dur ? RST_LONG_CYC : RST_SHORT_CYC;
                end
            end
            default: next_s_st = pss_pkg::SF_OFF;
        endcase
        if (s_st == pss_pkg::SF_INIT || s_st == pss_pkg::SF_WATCH) begin
            if (bist2_req_i && !b2_run) begin
                next_b2_run = 1'b1;
            end else if (b2_run && bist2_done_i) begin
                next_b2_run = 1'b0;
                next_b2_ok = bist2_pass_i;
            end
            if (safe_fault_i) begin
                next_fs0_rel = 1'b0;
                next_fs1_rel = 1'b0;
            end else if (safe_release_req_i && b1_ok && (b2_ok || !aux_critical_i)) begin
                next_fs0_rel = 1'b1;
                next_fs1_rel = b2_ok;
            end
        end
        if (safe_restart) begin
            next_s_st = pss_pkg::SF_OFF;
            next_long_rst = 1'b1;
            next_rst_dur = `PSS_RST_DUR_RST;
            next_b1_ok = 1'b0;
            next_b2_ok = 1'b0;
            next_b2_run = 1'b0;
            next_fs0_rel = 1'b0;
            next_fs1_rel = 1'b0;
            next_s_cnt = 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_st <= pss_pkg::SF_OFF;
            s_cnt <= 32'h0;
            long_rst <= 1'b1;
            rst_dur <= `PSS_RST_DUR_RST;
            b1_ok <= 1'b0;
            b2_ok <= 1'b0;
            b2_run <= 1'b0;
            fs0_rel <= 1'b0;
            fs1_rel <= 1'b0;
        end else begin
            s_st <= next_s_st;
            s_cnt <= next_s_cnt;
            long_rst <= next_long_rst;
            rst_dur <= next_rst_dur;
            b1_ok <= next_b1_ok;
            b2_ok <= next_b2_ok;
            b2_run <= next_b2_run;
            fs0_rel <= next_fs0_rel;
            fs1_rel <= next_fs1_rel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    logic regs_on, lp_mode;
    assign reset_low = !(s_st == pss_pkg::SF_INIT || s_st == pss_pkg::SF_WATCH);
    assign regs_on = (m_st == pss_pkg::MM_REGS) || (m_st == pss_pkg::MM_INIT) || (m_st == pss_pkg::MM_NORMAL);
    assign lp_mode = (m_st == pss_pkg::MM_SLEEP) || (m_st == pss_pkg::MM_AUTOWU) || (m_st == pss_pkg::MM_LP_DEEPFS)
        || (m_st == pss_pkg::MM_DEEPFS);

    assign lowside_gate_pin_src_o = (m_st == pss_pkg::MM_TOPO);
    assign pre_regulator_output_en_o = !lp_mode && (m_st != pss_pkg::MM_TOPO);
    assign core_supply_en_o = regs_on;
    assign auxiliary_supply_en_o = regs_on;
    assign analog_ref_supply_en_o = regs_on;
    assign transceiver_supply_en_o = regs_on;
    assign keep_alive_supply_en_o = keep_alive_used_i;
    assign buck_boost_o = buck_boost;
    assign supply_level_sel_o = lvl_sel;
    assign deep_fs_en_o = deep_fs_en;
    assign init_reg_o = init_reg;
    assign init_locked_o = init_locked;
    assign wake_source_o = wake_src;
    assign bist1_run_o = (s_st == pss_pkg::SF_BIST);
    assign bist2_run_o = b2_run;
    assign bist1_ok_o = b1_ok;
    assign bist2_ok_o = b2_ok;
    assign mcu_reset_out_low_o = !reset_low;
    assign primary_safe_out_o = fs0_rel && !reset_low;
    assign secondary_safe_out_o = fs1_rel && !reset_low;
    assign safety_init_phase_o = (s_st == pss_pkg::SF_INIT);
    assign reset_duration_config_o = rst_dur;
    assign main_state_o = m_st;
    assign safe_state_o = s_st;
endmodule // pss_sequencer
`default_nettype wire

/* sim/pss_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host: commits main init, then sends first refresh
module pss_host_model (
    input wire logic clk_i,
    input wire logic mcu_reset_out_low_i,
    input wire logic [3:0] main_state_i,
    output logic commit_write_o,
    output logic refresh_ok_o
);
    initial begin
        commit_write_o = 1'h0;
        refresh_ok_o = 1'h0;
        forever begin
            @(posedge mcu_reset_out_low_i);
            repeat (12) @(negedge clk_i);
            commit_write_o = (main_state_i == pss_pkg::MM_INIT);
            @(negedge clk_i);
            commit_write_o = 1'h0;
            repeat (12) @(negedge clk_i);
            refresh_ok_o = 1'h1;
            @(negedge clk_i);
            refresh_ok_o = 1'h0;
        end
    end
endmodule // pss_host_model
`default_nettype wire

/* sim/pss_seq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pss_seq_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic commit_write_i,
    input wire logic init_write_i,
    input wire logic pre_regulator_low_threshold_i,
    input wire logic refresh_ok_i,
    input wire logic fault_i,
    input wire logic ext_reset_req_i,
    input wire logic low_power_off_cmd_i,
    input wire logic [7:0] low_power_off_key_i,
    input wire logic deep_fs_event_i,
    input wire logic lowside_gate_pin_src_o,
    input wire logic pre_regulator_output_en_o,
    input wire logic core_supply_en_o,
    input wire logic auxiliary_supply_en_o,
    input wire logic analog_ref_supply_en_o,
    input wire logic transceiver_supply_en_o,
    input wire logic [7:0] init_reg_o,
    input wire logic init_locked_o,
    input wire logic bist1_ok_o,
    input wire logic mcu_reset_out_low_o,
    input wire logic primary_safe_out_o,
    input wire logic [3:0] main_state_o,
    input wire logic [2:0] safe_state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_enter_assert;
        $rose(safe_state_o == pss_pkg::SF_ASSERT);
    endsequence
    a_topo_gate_src: assert property (main_state_o == pss_pkg::MM_TOPO |-> lowside_gate_pin_src_o)
        else $error("gate source off");
    a_supplies_together: assert property (core_supply_en_o == auxiliary_supply_en_o &&
        core_supply_en_o == analog_ref_supply_en_o && core_supply_en_o == transceiver_supply_en_o)
        else $error("supplies split");
    a_commit_to_normal: assert property (main_state_o == pss_pkg::MM_INIT && commit_write_i
        && !pre_regulator_low_threshold_i |=> main_state_o == pss_pkg::MM_NORMAL && init_locked_o)
        else $error("commit ignored");
    a_locked_write_ignored: assert property (init_locked_o && init_write_i |=> $stable(init_reg_o))
        else $error("locked write taken");
    a_refresh_to_watch: assert property (safe_state_o == pss_pkg::SF_INIT && refresh_ok_i && !fault_i
        && !ext_reset_req_i |=> safe_state_o == pss_pkg::SF_WATCH)
        else $error("refresh ignored");
    a_bist_gates_safe: assert property (primary_safe_out_o |-> bist1_ok_o)
        else $error("safe out without self-test");
    a_bad_key_ignored: assert property (main_state_o == pss_pkg::MM_NORMAL && low_power_off_cmd_i && low_power_off_key_i != 8'hA5
        && !pre_regulator_low_threshold_i && !deep_fs_event_i |=> main_state_o == pss_pkg::MM_NORMAL)
        else $error("bad key obeyed");
    a_reset_hold: assert property (s_enter_assert |-> !mcu_reset_out_low_o [*8])
        else $error("reset released early");
    a_sleep_off: assert property (main_state_o == pss_pkg::MM_SLEEP |-> !core_supply_en_o
        && !pre_regulator_output_en_o && !transceiver_supply_en_o)
        else $error("regulator on in sleep");
endmodule // pss_seq_sva
bind pss_sequencer pss_seq_sva i_sva (.*);
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int RL = 60;
    localparam int RS = 30;
    logic clk_i, rst_n_i, gate_sense_high_i, pre_soft_done_i, regs_soft_done_i, pre_regulator_low_threshold_i;
    logic init_write_i, commit_write_i, low_power_off_cmd_i, keep_alive_used_i, wake_can_i, wake_io_i, wake_timer_i;
    logic deep_fs_event_i, key_io_i, bist1_done_i, bist1_pass_i, bist2_req_i, bist2_done_i, bist2_pass_i;
    logic aux_critical_i, rst_dur_write_i, rst_dur_long_i, refresh_ok_i, fault_i, ext_reset_req_i;
    logic safe_release_req_i, safe_fault_i, lowside_gate_pin_src_o, pre_regulator_output_en_o, core_supply_en_o;
    logic auxiliary_supply_en_o, analog_ref_supply_en_o, transceiver_supply_en_o, keep_alive_supply_en_o;
    logic buck_boost_o, deep_fs_en_o, init_locked_o, bist1_run_o, bist2_run_o, bist1_ok_o, bist2_ok_o;
    logic mcu_reset_out_low_o, primary_safe_out_o, secondary_safe_out_o, safety_init_phase_o;
    logic reset_duration_config_o;
    logic [1:0] config_pin_code_i, low_power_off_code_i, supply_level_sel_o;
    logic [7:0] init_data_i, low_power_off_key_i, init_reg_o, d1;
    logic [2:0] wake_source_o, safe_state_o;
    logic [3:0] main_state_o;
    logic g, dl;
    int error_cnt, checks_done, n, w;
    pss_sequencer #(.AUTOWU_CYC(20), .RST_SHORT_CYC(RS), .RST_LONG_CYC(RL), .INIT_WIN_CYC(200)) i_dut (.*);
    pss_host_model i_host (.clk_i, .mcu_reset_out_low_i(mcu_reset_out_low_o), .main_state_i(main_state_o),
        .commit_write_o(commit_write_i), .refresh_ok_o(refresh_ok_i));
    ////////////////////////////////////////////////////////////////
    function automatic int exp_rst(input logic long_sel);
        return long_sel ? RL : RS;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_st(input logic safe, input logic [3:0] st);
        n = 0;
        while ((safe ? {1'h0, safe_state_o} : main_state_o) !== st && n < 30000) begin
            @(negedge clk_i);
            n++;
        end
        chk(8'(n < 30000), 8'h01);
    endtask
    task automatic count_low(input int e);
        n = 0;
        while (mcu_reset_out_low_o === 1'h0 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        chk(8'(n >= e - 1 && n <= e + 2), 8'h01);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #400us;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {rst_n_i, gate_sense_high_i, pre_soft_done_i, regs_soft_done_i, pre_regulator_low_threshold_i, init_write_i,
            low_power_off_cmd_i, keep_alive_used_i, wake_can_i, wake_io_i, wake_timer_i, deep_fs_event_i, key_io_i,
            bist1_done_i, bist1_pass_i, bist2_req_i, bist2_done_i, bist2_pass_i, aux_critical_i, rst_dur_write_i,
            rst_dur_long_i, fault_i, ext_reset_req_i, safe_release_req_i, safe_fault_i, config_pin_code_i,
            low_power_off_code_i, init_data_i, low_power_off_key_i} = '0;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(26));
        g = 1'($urandom);
        dl = 1'($urandom);
        d1 = 8'($urandom);
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'h1;
        {gate_sense_high_i, config_pin_code_i, keep_alive_used_i} = {g, 2'($urandom), 1'($urandom)};
        {pre_soft_done_i, regs_soft_done_i, bist1_done_i, bist1_pass_i} = 4'hF;
        wait_st(1'h1, 4'(pss_pkg::SF_RELEASE));
        count_low(RL);
        @(negedge clk_i);
        {rst_dur_write_i, rst_dur_long_i, init_write_i, init_data_i, bist2_req_i} = {1'h1, dl, 1'h1, d1, 1'h1};
        @(negedge clk_i);
        {rst_dur_write_i, init_write_i, bist2_req_i, bist2_done_i, bist2_pass_i} = 5'h03;
        chk(main_state_o, 8'(pss_pkg::MM_INIT));
        chk(buck_boost_o, g);
        chk({deep_fs_en_o, supply_level_sel_o}, {config_pin_code_i[1], config_pin_code_i});
        chk({core_supply_en_o, transceiver_supply_en_o, primary_safe_out_o}, 8'h06);
        chk({safety_init_phase_o, bist2_run_o}, 8'h03);
        $display("power-up test done");
        wait_st(1'h0, pss_pkg::MM_NORMAL);
        {init_write_i, init_data_i} = {1'h1, ~d1};
        @(negedge clk_i);
        init_write_i = 1'h0;
        @(negedge clk_i);
        chk({init_locked_o, init_reg_o}, {1'h1, d1});
        $display("init lock test done");
        wait_st(1'h1, 4'(pss_pkg::SF_WATCH));
        safe_release_req_i = 1'h1;
        @(negedge clk_i);
        safe_release_req_i = 1'h0;
        repeat (2) @(negedge clk_i);
        chk({primary_safe_out_o, secondary_safe_out_o, reset_duration_config_o}, {2'h3, dl});
        $display("release test done");
        {low_power_off_cmd_i, low_power_off_key_i, low_power_off_code_i} = {1'h1, 8'h5A, 2'h1};
        @(negedge clk_i);
        {low_power_off_cmd_i, fault_i} = 2'h1;
        @(negedge clk_i);
        chk(main_state_o, 8'(pss_pkg::MM_NORMAL));
        fault_i = 1'h0;
        wait_st(1'h1, 4'(pss_pkg::SF_ASSERT));
        count_low(exp_rst(dl));
        chk(main_state_o, 8'(pss_pkg::MM_NORMAL));
        wait_st(1'h1, 4'(pss_pkg::SF_WATCH));
        $display("fault test done");
        {low_power_off_cmd_i, low_power_off_key_i} = {1'h1, 8'hA5};
        @(negedge clk_i);
        low_power_off_cmd_i = 1'h0;
        wait_st(1'h0, pss_pkg::MM_SLEEP);
        chk({core_supply_en_o, keep_alive_supply_en_o}, {1'h0, keep_alive_used_i});
        w = $urandom_range(2, 0);
        {wake_timer_i, wake_io_i, wake_can_i} = 3'h1 << w;
        wait_st(1'h0, pss_pkg::MM_TOPO);
        {wake_timer_i, wake_io_i, wake_can_i} = 3'h0;
        chk(wake_source_o, 8'h01 << w);
        wait_st(1'h0, pss_pkg::MM_INIT);
        chk({init_reg_o, reset_duration_config_o, core_supply_en_o, primary_safe_out_o},
            {d1, 3'h2});
        wait_st(1'h0, pss_pkg::MM_NORMAL);
        pre_regulator_low_threshold_i = 1'h1;
        wait_st(1'h0, pss_pkg::MM_AUTOWU);
        $display("low-power test done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
